// ### rtl/hch_handshake.sv
// Command handshake, event flags and host interrupt logic of the port adapter.
// What this block does
// - Host transfer command clears the controller ready flag.
// - Setting a pending bit raises the command ready event flag.
// - Posting drive status clears the pending bit.
// - Writing drive status sets the ready flag.
// - Completion interrupts the host only with interrupt permit set.
// - Programmed reset or bus init sets an event flag and interrupts microprocessor.
// - Reset detection uses an interrupt, never polling.
// - A reset touches only this adapter.
// - Bus init clears permit, sets ready, clears all pending bits.
// - Leading edge of bus init sets set-ready flag and interrupts.
// - Init, controller clear and error clear interrupt microprocessor; transfer and drive clear set flag.
// - Transfer while not ready sets program error; function and pending still written.
// - Microprocessor write of control register sets the completion interrupt latch.
// - Loading the event identity slot sets the event interrupt latch.
// - Bits 12 to 15 of control register identify the interrupt cause.
// - Host interrupts pass only while the controller is ready.
// - One event interrupt at a time; microprocessor queues and paces others.
// - Host commands queue in a FIFO the microprocessor reads.
// - Registers live in a RAM file, eight locations per drive.
// - One discrete pending bit for each of eight drives.
// - Command completion preempts pending event completion and sets ready.
// - Each event interrupt carries a five-bit identifier.
// - Simultaneous file requests are served one after the other.
`timescale 1ns/1ns
module hch_handshake
  import hch_pkg::*;
#(
  parameter int DRIVES = HCH_DRIVES,
  parameter int FIFO_DEPTH = HCH_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_init_pin,
  input wire hch_host_cmd_t host_cmd,
  input wire logic host_permit_wr,
  input wire logic host_permit_val,
  input wire logic host_irq_ack,
  input wire hch_file_req_t host_file_req,
  input wire hch_file_req_t mp_file_req,
  input wire logic mp_status_post,
  input wire logic mp_cs1_write,
  input wire logic mp_event_load,
  input wire logic [HCH_EVID_W-1:0] mp_event_id,
  input wire logic [7:0] mp_evf_clear,
  input wire logic mp_fifo_pop,
  output logic controller_ready,
  output logic interrupt_permit,
  output logic [DRIVES-1:0] cmd_pending,
  output logic [7:0] event_flags,
  output logic mp_irq,
  output logic host_irq,
  output logic program_error_status,
  output logic [3:0] control_status_one_hi,
  output logic [HCH_EVID_W-1:0] event_identity_slot,
  output logic [HCH_FUNC_W+HCH_SEL_W-1:0] fifo_head,
  output logic fifo_nonempty,
  output logic [HCH_DATA_W-1:0] host_file_rdata,
  output logic host_file_done,
  output logic [HCH_DATA_W-1:0] mp_file_rdata,
  output logic mp_file_done
);

  // ------------------------------------------------------------
  // Bus initialize synchroniser and leading edge
  // ------------------------------------------------------------
  logic init_meta_r, init_sync_r, init_prev_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      init_meta_r <= 1'b0;
      init_sync_r <= 1'b0;
      init_prev_r <= 1'b0;
    end else begin
      init_meta_r <= bus_init_pin;
      init_sync_r <= init_meta_r;
      init_prev_r <= init_sync_r;
    end
  end

  logic init_rise;
  assign init_rise = init_sync_r & ~init_prev_r;

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic is_xfer, is_dclr, is_cclr, is_eclr;
  assign is_xfer = host_cmd.valid && host_cmd.kind == HCH_CMD_TRANSFER;
  assign is_dclr = host_cmd.valid && host_cmd.kind == HCH_CMD_DRIVE_CLR;
  assign is_cclr = host_cmd.valid && host_cmd.kind == HCH_CMD_CTRL_CLR;
  assign is_eclr = host_cmd.valid && host_cmd.kind == HCH_CMD_ERR_CLR;

  // Reset sources local to this adapter only; nothing leaves toward other ports.
  logic local_reset;
  assign local_reset = init_sync_r | is_cclr;

  // ------------------------------------------------------------
  // Handshake state: ready, permit, pending, error, unit select
  // ------------------------------------------------------------
  logic ready_r, ready_nxt;
  logic permit_r, permit_nxt;
  logic [DRIVES-1:0] pend_r, pend_nxt;
  logic pge_r, pge_nxt;
  logic [HCH_SEL_W-1:0] unit_r, unit_nxt;

  // Completion wins over a same-cycle transfer so that status is never lost.
  always_comb begin
    ready_nxt = ready_r;
    permit_nxt = permit_r;
    pend_nxt = pend_r;
    pge_nxt = pge_r;
    unit_nxt = unit_r;
    if (host_permit_wr) begin
      permit_nxt = host_permit_val;
    end
    if (is_xfer) begin
      if (!ready_r) begin
        pge_nxt = 1'b1;
      end
      ready_nxt = 1'b0;
      unit_nxt = host_cmd.unit;
      pend_nxt[host_cmd.unit] = 1'b1;
    end
    if (is_eclr) begin
      pge_nxt = 1'b0;
    end
    if (mp_status_post) begin
      pend_nxt[unit_r] = 1'b0;
      ready_nxt = 1'b1;
    end
    if (local_reset) begin
      permit_nxt = 1'b0;
      ready_nxt = 1'b1;
      pend_nxt = '0;
      pge_nxt = 1'b0;
      unit_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ready_r <= HCH_RST_READY;
      permit_r <= 1'b0;
      pend_r <= '0;
      pge_r <= 1'b0;
      unit_r <= '0;
    end else begin
      ready_r <= ready_nxt;
      permit_r <= permit_nxt;
      pend_r <= pend_nxt;
      pge_r <= pge_nxt;
      unit_r <= unit_nxt;
    end
  end

  // ------------------------------------------------------------
  // Event flags and microprocessor interrupt
  // ------------------------------------------------------------
  logic [7:0] evf_r, evf_nxt;
  logic mp_irq_r, mp_irq_nxt;

  // Sets win over clears so a reset arriving during a clear is kept.
  always_comb begin
    evf_nxt = evf_r & ~mp_evf_clear;
    mp_irq_nxt = mp_irq_r;
    if (mp_evf_clear != 8'h00) begin
      mp_irq_nxt = 1'b0;
    end
    if (is_xfer || is_dclr) begin
      evf_nxt[HCH_EVF_GC] = 1'b1;
    end
    if (is_eclr) begin
      evf_nxt[HCH_EVF_EC] = 1'b1;
      mp_irq_nxt = 1'b1;
    end
    if (is_cclr) begin
      evf_nxt[HCH_EVF_PR] = 1'b1;
      mp_irq_nxt = 1'b1;
    end
    if (init_rise) begin
      evf_nxt[HCH_EVF_SR] = 1'b1;
      mp_irq_nxt = 1'b1;
    end
    if (is_xfer && !ready_r) begin
      evf_nxt[HCH_EVF_ACE] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evf_r <= 8'h00;
      mp_irq_r <= 1'b0;
    end else begin
      evf_r <= evf_nxt;
      mp_irq_r <= mp_irq_nxt;
    end
  end

  // ------------------------------------------------------------
  // Host interrupt latches and sequencer
  // ------------------------------------------------------------
  logic cmd_latch_r, cmd_latch_nxt;
  logic ev_latch_r, ev_latch_nxt;
  logic [HCH_EVID_W-1:0] evid_r, evid_nxt;
  logic [3:0] cause_r, cause_nxt;
  hch_irq_state_t irq_st_r, irq_st_nxt;
  logic host_irq_r, host_irq_nxt;

  // Only one event is held; a second load while busy is left to firmware pacing.
  always_comb begin
    cmd_latch_nxt = cmd_latch_r;
    ev_latch_nxt = ev_latch_r;
    evid_nxt = evid_r;
    cause_nxt = cause_r;
    irq_st_nxt = irq_st_r;
    host_irq_nxt = 1'b0;
    if (mp_cs1_write || mp_status_post) begin
      cmd_latch_nxt = 1'b1;
    end
    if (mp_event_load && !ev_latch_r) begin
      ev_latch_nxt = 1'b1;
      evid_nxt = mp_event_id;
    end
    unique case (irq_st_r)
      HCH_IRQ_IDLE: begin
        if (permit_r && ready_nxt && cmd_latch_r) begin
          irq_st_nxt = HCH_IRQ_CMD;
          cause_nxt = 4'h1;
          // A completion posted in this very cycle must stay latched for the next round.
          cmd_latch_nxt = mp_cs1_write || mp_status_post;
        end else if (permit_r && ready_r && ev_latch_r) begin
          irq_st_nxt = HCH_IRQ_EVT;
          cause_nxt = 4'h2;
        end
      end
      HCH_IRQ_CMD, HCH_IRQ_EVT: begin
        // The request is held off while busy or not permitted, and shows again later.
        host_irq_nxt = ready_nxt && permit_nxt;
        if (host_irq_ack) begin
          irq_st_nxt = HCH_IRQ_IDLE;
          host_irq_nxt = 1'b0;
          if (irq_st_r == HCH_IRQ_EVT) begin
            ev_latch_nxt = 1'b0;
          end
        end
      end
      default: irq_st_nxt = HCH_IRQ_IDLE;
    endcase
    if (local_reset) begin
      cmd_latch_nxt = 1'b0;
      ev_latch_nxt = 1'b0;
      irq_st_nxt = HCH_IRQ_IDLE;
      host_irq_nxt = 1'b0;
      cause_nxt = 4'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_latch_r <= 1'b0;
      ev_latch_r <= 1'b0;
      evid_r <= '0;
      cause_r <= 4'h0;
      irq_st_r <= HCH_IRQ_IDLE;
      host_irq_r <= 1'b0;
    end else begin
      cmd_latch_r <= cmd_latch_nxt;
      ev_latch_r <= ev_latch_nxt;
      evid_r <= evid_nxt;
      cause_r <= cause_nxt;
      irq_st_r <= irq_st_nxt;
      host_irq_r <= host_irq_nxt;
    end
  end

  // ------------------------------------------------------------
  // Command FIFO
  // ------------------------------------------------------------
  localparam int FW = HCH_FUNC_W + HCH_SEL_W;
  logic [FW-1:0] fifo_mem_r [FIFO_DEPTH];
  logic [FW-1:0] fifo_mem_nxt [FIFO_DEPTH];
  logic [HCH_FIFO_AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic fifo_full, fifo_empty, push, pop;

  assign fifo_empty = wp_r == rp_r;
  assign fifo_full = (wp_r[HCH_FIFO_AW] != rp_r[HCH_FIFO_AW]) &&
    (wp_r[HCH_FIFO_AW-1:0] == rp_r[HCH_FIFO_AW-1:0]);
  // A full queue drops the newest command; firmware drains faster than hosts issue.
  assign push = host_cmd.valid && host_cmd.kind != HCH_CMD_NONE && !fifo_full;
  assign pop = mp_fifo_pop && !fifo_empty;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      fifo_mem_nxt[i] = fifo_mem_r[i];
    end
    if (push) begin
      fifo_mem_nxt[wp_r[HCH_FIFO_AW-1:0]] = {host_cmd.func, host_cmd.unit};
      wp_nxt = wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = rp_r + 1'b1;
    end
    if (local_reset) begin
      wp_nxt = '0;
      rp_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_mem_r[i] <= '0;
      end
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_mem_r[i] <= fifo_mem_nxt[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Register file with tie-breaker
  // ------------------------------------------------------------
  logic host_wait_r, host_wait_nxt;
  hch_file_req_t held_r, held_nxt;
  logic grant_host, grant_mp;
  hch_file_req_t sel;
  logic ram_we;
  logic [HCH_DATA_W-1:0] ram_q;
  logic hdone_r, hdone_nxt, mdone_r, mdone_nxt;
  logic hpend_r, mpend_r;

  // The microprocessor wins a tie; the host request is held and served next.
  always_comb begin
    held_nxt = held_r;
    host_wait_nxt = 1'b0;
    grant_mp = mp_file_req.valid;
    grant_host = 1'b0;
    sel = mp_file_req;
    if (host_wait_r && !mp_file_req.valid) begin
      grant_host = 1'b1;
      sel = held_r;
    end else if (host_wait_r) begin
      host_wait_nxt = 1'b1;
    end else if (host_file_req.valid && mp_file_req.valid) begin
      held_nxt = host_file_req;
      host_wait_nxt = 1'b1;
    end else if (host_file_req.valid) begin
      grant_host = 1'b1;
      sel = host_file_req;
    end
    hdone_nxt = grant_host;
    mdone_nxt = grant_mp;
  end

  assign ram_we = (grant_host || grant_mp) && sel.write;

  // Eight locations per drive: the request address goes to the RAM unchanged.
  hch_file_ram #(.AW(HCH_FILE_AW), .DW(HCH_DATA_W)) u_file (
    .ref_clk(ref_clk),
    .we(ram_we),
    .addr(sel.addr),
    .wdata(sel.data),
    .rdata(ram_q)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      held_r <= '0;
      host_wait_r <= 1'b0;
      hpend_r <= 1'b0;
      mpend_r <= 1'b0;
      hdone_r <= 1'b0;
      mdone_r <= 1'b0;
      host_file_rdata <= '0;
      mp_file_rdata <= '0;
    end else begin
      held_r <= held_nxt;
      host_wait_r <= host_wait_nxt;
      hpend_r <= hdone_nxt;
      mpend_r <= mdone_nxt;
      hdone_r <= hpend_r;
      mdone_r <= mpend_r;
      host_file_rdata <= hpend_r ? ram_q : host_file_rdata;
      mp_file_rdata <= mpend_r ? ram_q : mp_file_rdata;
    end
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fifo_head <= '0;
      fifo_nonempty <= 1'b0;
    end else begin
      fifo_head <= fifo_mem_nxt[rp_nxt[HCH_FIFO_AW-1:0]];
      fifo_nonempty <= wp_nxt != rp_nxt;
    end
  end

  assign controller_ready = ready_r;
  assign interrupt_permit = permit_r;
  assign cmd_pending = pend_r;
  assign event_flags = evf_r;
  assign mp_irq = mp_irq_r;
  assign host_irq = host_irq_r;
  assign program_error_status = pge_r;
  assign control_status_one_hi = cause_r;
  assign event_identity_slot = evid_r;
  assign host_file_done = hdone_r;
  assign mp_file_done = mdone_r;

endmodule // hch_handshake

// ### rtl/hch_pkg.sv
// Package of constants and carrier types for the host command handshake block.
package hch_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int HCH_DRIVES = 8;
  localparam int HCH_SEL_W = 3;
  localparam int HCH_FUNC_W = 5;
  localparam int HCH_EVID_W = 5;
  localparam int HCH_DATA_W = 16;
  localparam int HCH_FILE_AW = 7;
  localparam int HCH_FIFO_DEPTH = 8;
  localparam int HCH_FIFO_AW = 3;
  localparam int HCH_REGS_PER_DRIVE = 8;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic HCH_RST_READY = 1'b1;
  localparam logic [7:0] HCH_RST_PENDING = 8'h00;

  // ------------------------------------------------------------
  // Field positions in the first control and status register
  // ------------------------------------------------------------
  localparam int HCH_CS1_ID_LO = 12;
  localparam int HCH_CS1_ID_HI = 15;
  localparam int HCH_CS1_READY = 7;
  localparam int HCH_CS1_PERMIT = 6;

  // Event flag bit positions toward the microprocessor.
  localparam int HCH_EVF_ACE = 0;
  localparam int HCH_EVF_SR = 1;
  localparam int HCH_EVF_PR = 2;
  localparam int HCH_EVF_EC = 6;
  localparam int HCH_EVF_GC = 7;

  // Host command kinds.
  typedef enum logic [2:0] {
    HCH_CMD_NONE = 3'h0,
    HCH_CMD_TRANSFER = 3'h1,
    HCH_CMD_DRIVE_CLR = 3'h2,
    HCH_CMD_CTRL_CLR = 3'h3,
    HCH_CMD_ERR_CLR = 3'h4
  } hch_cmd_t;

  // Host command as it arrives from host bus decode.
  typedef struct packed {
    logic valid;
    hch_cmd_t kind;
    logic [HCH_FUNC_W-1:0] func;
    logic [HCH_SEL_W-1:0] unit;
  } hch_host_cmd_t;

  // Register file request from the host or the microprocessor.
  typedef struct packed {
    logic valid;
    logic write;
    logic [HCH_FILE_AW-1:0] addr;
    logic [HCH_DATA_W-1:0] data;
  } hch_file_req_t;

  // Host interrupt sequencer states, Gray coded.
  typedef enum logic [1:0] {
    HCH_IRQ_IDLE = 2'b00,
    HCH_IRQ_CMD = 2'b01,
    HCH_IRQ_EVT = 2'b11
  } hch_irq_state_t;

endpackage

// ### rtl/hch_file_ram.sv
// Register file memory shared by host and microprocessor, registered read data.
`timescale 1ns/1ns
module hch_file_ram
  import hch_pkg::*;
#(
  parameter int AW = HCH_FILE_AW,
  parameter int DW = HCH_DATA_W
) (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Read first: a same-cycle write returns the old word; read data registered for a clean timing path.
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // hch_file_ram

// ### dv/hch_handshake_assertions.sv
// Concurrent checks on the ports of the host command handshake block.
`timescale 1ns/1ns
module hch_handshake_assertions
  import hch_pkg::*;
#(
  parameter int DRIVES = HCH_DRIVES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_init_pin,
  input wire hch_host_cmd_t host_cmd,
  input wire logic mp_status_post,
  input wire logic controller_ready,
  input wire logic interrupt_permit,
  input wire logic [DRIVES-1:0] cmd_pending,
  input wire logic [7:0] event_flags,
  input wire logic mp_irq,
  input wire logic host_irq
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic [HCH_SEL_W-1:0] unit_r;
  logic [HCH_SEL_W-1:0] unit_nxt;
  logic xfer;
  // A post releases the unit of the latest transfer, so that unit is remembered here.
  always_comb begin
    xfer = host_cmd.valid && host_cmd.kind == HCH_CMD_TRANSFER && !bus_init_pin;
    unit_nxt = xfer ? host_cmd.unit : unit_r;
  end
  // Registers the remembered unit.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unit_r <= '0;
    end else begin
      unit_r <= unit_nxt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_xfer_drops_ready: assert property (
    xfer && !mp_status_post |=> !controller_ready) else $error("ready held after transfer");
  a_xfer_sets_pending: assert property (
    xfer |=> cmd_pending[$past(host_cmd.unit)] && event_flags[HCH_EVF_GC])
    else $error("transfer left pending or flag clear");
  a_post_sets_ready: assert property (
    mp_status_post && !host_cmd.valid |=> controller_ready) else $error("post left ready low");
  a_post_frees_unit: assert property (
    mp_status_post && !host_cmd.valid |=> !cmd_pending[unit_r]) else $error("post kept pending");
  a_init_sets_flag: assert property (
    $rose(bus_init_pin) |-> ##[2:4] (event_flags[HCH_EVF_SR] && mp_irq))
    else $error("init raised no set ready interrupt");
  a_init_clears_state: assert property (
    bus_init_pin [*5] |-> controller_ready && cmd_pending == '0 && !interrupt_permit)
    else $error("init did not clear state");
  a_irq_needs_permit: assert property (
    $rose(host_irq) |-> interrupt_permit) else $error("host interrupt without permit");
  a_irq_needs_ready: assert property (
    $rose(host_irq) |-> controller_ready) else $error("host interrupt while busy");
endmodule // hch_handshake_assertions

bind hch_handshake hch_handshake_assertions #(.DRIVES(DRIVES)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .bus_init_pin(bus_init_pin), .host_cmd(host_cmd),
  .mp_status_post(mp_status_post), .controller_ready(controller_ready),
  .interrupt_permit(interrupt_permit), .cmd_pending(cmd_pending),
  .event_flags(event_flags), .mp_irq(mp_irq), .host_irq(host_irq));

// ### dv/hch_far_side.sv
// Behavioural model of the host processor and the controller microprocessor.
`timescale 1ns/1ns
module hch_far_side
  import hch_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic host_irq,
  input wire logic mp_irq,
  input wire logic [7:0] event_flags,
  output logic host_irq_ack,
  output logic [7:0] mp_evf_clear
);
  logic [3:0] wait_r;
  logic [3:0] wait_nxt;
  logic ack_nxt;
  logic [7:0] clear_nxt;
  // The host needs some cycles to service an interrupt; slow mode stretches that time.
  always_comb begin
    wait_nxt = (host_irq && !host_irq_ack) ? wait_r + 4'h1 : 4'h0;
    ack_nxt = host_irq && !host_irq_ack && (wait_r == (slow ? 4'hC : 4'h2));
    clear_nxt = 8'h00;
    if (mp_irq && (event_flags[HCH_EVF_SR] || event_flags[HCH_EVF_PR])) begin
      clear_nxt = 8'h06;
    end
  end
  // Registers the answers so they change only after a clock edge.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_r <= 4'h0;
      host_irq_ack <= 1'b0;
      mp_evf_clear <= 8'h00;
    end else begin
      wait_r <= wait_nxt;
      host_irq_ack <= ack_nxt;
      mp_evf_clear <= clear_nxt;
    end
  end
endmodule // hch_far_side

// ### dv/test_hch_handshake.sv
// Self-checking testbench for the host command handshake block.
`timescale 1ns/1ns
module test_hch_handshake;
  import hch_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  typedef struct packed {
    hch_cmd_t kind; logic [2:0] unit; logic rdy; logic [7:0] flags;
  } hch_row_t;
  logic ref_clk = 1'b0, rst = 1'b1, bus_init_pin = 1'b0, slow = 1'b0;
  logic host_permit_wr = 1'b0, host_permit_val = 1'b0, host_irq_ack;
  logic mp_status_post = 1'b0, mp_cs1_write = 1'b0, mp_event_load = 1'b0, mp_fifo_pop = 1'b0;
  hch_host_cmd_t host_cmd = '0;
  hch_file_req_t host_file_req = '0, mp_file_req = '0;
  logic [4:0] mp_event_id = 5'h15, event_identity_slot;
  logic [7:0] tb_clear = 8'h00, far_clear, cmd_pending, event_flags, fifo_head;
  logic controller_ready, interrupt_permit, mp_irq, host_irq, program_error_status;
  logic fifo_nonempty, host_file_done, mp_file_done;
  logic [3:0] control_status_one_hi, n_done;
  logic [15:0] host_file_rdata, mp_file_rdata;
  int n_errors = 0, check_count = 0, cycles = 0;
  hch_row_t rows [5] = '{'{HCH_CMD_TRANSFER, 3'h0, 1'b0, 8'h80},
    '{HCH_CMD_TRANSFER, 3'h7, 1'b0, 8'h80}, '{HCH_CMD_DRIVE_CLR, 3'h3, 1'b1, 8'h80},
    '{HCH_CMD_CTRL_CLR, 3'h2, 1'b1, 8'h04}, '{HCH_CMD_ERR_CLR, 3'h5, 1'b1, 8'h40}};
  hch_handshake dut_u (.ref_clk(ref_clk), .rst(rst), .bus_init_pin(bus_init_pin),
    .host_cmd(host_cmd), .host_permit_wr(host_permit_wr), .host_permit_val(host_permit_val),
    .host_irq_ack(host_irq_ack), .host_file_req(host_file_req), .mp_file_req(mp_file_req),
    .mp_status_post(mp_status_post), .mp_cs1_write(mp_cs1_write),
    .mp_event_load(mp_event_load), .mp_event_id(mp_event_id),
    .mp_evf_clear(tb_clear | far_clear), .mp_fifo_pop(mp_fifo_pop),
    .controller_ready(controller_ready), .interrupt_permit(interrupt_permit),
    .cmd_pending(cmd_pending), .event_flags(event_flags), .mp_irq(mp_irq), .host_irq(host_irq),
    .program_error_status(program_error_status), .control_status_one_hi(control_status_one_hi),
    .event_identity_slot(event_identity_slot), .fifo_head(fifo_head),
    .fifo_nonempty(fifo_nonempty), .host_file_rdata(host_file_rdata),
    .host_file_done(host_file_done), .mp_file_rdata(mp_file_rdata), .mp_file_done(mp_file_done));
  hch_far_side far_u (.ref_clk(ref_clk), .rst(rst), .slow(slow), .host_irq(host_irq),
    .mp_irq(mp_irq), .event_flags(event_flags), .host_irq_ack(host_irq_ack),
    .mp_evf_clear(far_clear));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Counts every comparison; case inequality keeps unknowns from passing.
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Ends with an idle edge so a second pulse never lands in the same time step.
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(1);
  endtask
  // Leaves the command valid; the caller drops it, so back-to-back sends stay legal.
  task automatic send(hch_cmd_t kind, logic [2:0] unit);
    host_cmd = '{1'b1, kind, 5'h11, unit};
    step(1);
  endtask
  // Waits, bounded, for a host interrupt, checks its cause and waits for the ack to clear it.
  task automatic wait_irq(logic [3:0] cause);
    int i;
    for (i = 0; i < 40 && host_irq !== 1'b1; i++) step(1);
    check("host_irq", host_irq, 1'b1);
    check("cause", control_status_one_hi, cause);
    for (i = 0; i < 40 && host_irq === 1'b1; i++) step(1);
  endtask
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // A hang is cut short far past the fewer than two hundred cycles the sequence needs.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    step(12);
    rst = 1'b0;
    check("rst ready", controller_ready, 1'b1);
    check("rst state", {cmd_pending, event_flags}, 16'h0000);
    check("rst irq", {host_irq, mp_irq, interrupt_permit, fifo_nonempty}, 4'h0);
    foreach (rows[i]) begin
      send(rows[i].kind, rows[i].unit);
      check("ready", controller_ready, rows[i].rdy);
      if (rows[i].kind == HCH_CMD_TRANSFER) begin
        check("pending", cmd_pending, 8'h01 << rows[i].unit);
        check("fifo", {fifo_nonempty, fifo_head}, {1'b1, 5'h11, rows[i].unit});
      end
      host_cmd = '0;
      step(1);
      check("flags", event_flags & rows[i].flags, rows[i].flags);
      if (rows[i].flags != 8'h80) check("mp_irq", mp_irq, 1'b1);
      pulse(mp_status_post);
      check("ready", controller_ready, 1'b1);
      check("pending", cmd_pending, 8'h00);
      tb_clear = 8'hFF;
      repeat (2) pulse(mp_fifo_pop);
      tb_clear = 8'h00;
    end
    // A transfer issued while busy still lands, and a post frees only the latest unit.
    send(HCH_CMD_TRANSFER, 3'h1);
    send(HCH_CMD_TRANSFER, 3'h4);
    host_cmd = '0;
    check("pgm error", program_error_status, 1'b1);
    check("pending", cmd_pending, 8'h12);
    step(1);
    check("error flag", event_flags[HCH_EVF_ACE], 1'b1);
    pulse(mp_status_post);
    check("pending", cmd_pending, 8'h02);
    send(HCH_CMD_CTRL_CLR, 3'h0);
    host_cmd = '0;
    step(2);
    check("pending", cmd_pending, 8'h00);
    // Completion preempts an event held back while busy; the event follows it.
    host_permit_val = 1'b1;
    pulse(host_permit_wr);
    send(HCH_CMD_TRANSFER, 3'h3);
    host_cmd = '0;
    pulse(mp_event_load);
    check("event id", event_identity_slot, 5'h15);
    step(4);
    check("held irq", host_irq, 1'b0);
    pulse(mp_status_post);
    wait_irq(4'h1);
    slow = 1'b1;
    wait_irq(4'h2);
    pulse(mp_cs1_write);
    wait_irq(4'h1);
    host_permit_val = 1'b0;
    pulse(host_permit_wr);
    pulse(mp_cs1_write);
    step(6);
    check("no permit irq", host_irq, 1'b0);
    // Bus initialize in mid-command.
    host_permit_val = 1'b1;
    pulse(host_permit_wr);
    send(HCH_CMD_TRANSFER, 3'h6);
    host_cmd = '0;
    bus_init_pin = 1'b1;
    step(6);
    check("init", {controller_ready, interrupt_permit, cmd_pending}, 10'h200);
    bus_init_pin = 1'b0;
    step(4);
    // Simultaneous file writes must both be served, then each is read back by the other side.
    mp_file_req = '{1'b1, 1'b1, 7'h10, 16'hA5A5};
    host_file_req = '{1'b1, 1'b1, 7'h11, 16'h5A5A};
    step(1);
    mp_file_req = '0;
    host_file_req = '0;
    n_done = 4'h0;
    repeat (8) begin
      n_done = n_done + {3'h0, mp_file_done} + {3'h0, host_file_done};
      step(1);
    end
    check("both served", n_done, 4'h2);
    mp_file_req = '{1'b1, 1'b0, 7'h11, 16'h0000};
    step(1);
    mp_file_req = '0;
    for (int i = 0; i < 8 && mp_file_done !== 1'b1; i++) step(1);
    check("file data", mp_file_rdata, 16'h5A5A);
    host_file_req = '{1'b1, 1'b0, 7'h10, 16'h0000};
    step(1);
    host_file_req = '0;
    for (int i = 0; i < 8 && host_file_done !== 1'b1; i++) step(1);
    check("host file data", host_file_rdata, 16'hA5A5);
    conclude();
  end
endmodule // test_hch_handshake
